// >>> hdl/ppu_pkg.sv
// Constants shared by the pulse pattern unit and its next-data buffer.
// Assumes a 32-bit AHB-Lite slave port, byte addresses, one word per register.
package ppu_pkg;
  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_NEXT_ENABLE_HIGH = 8'h00;
  localparam logic [7:0] OFS_NEXT_ENABLE_LOW = 8'h04;
  localparam logic [7:0] OFS_OUT_VALUE_HIGH = 8'h08;
  localparam logic [7:0] OFS_OUT_VALUE_LOW = 8'h0C;
  localparam logic [7:0] OFS_NEXT_VALUE_HIGH = 8'h10;
  localparam logic [7:0] OFS_NEXT_VALUE_LOW = 8'h14;
  localparam logic [7:0] OFS_NEXT_VALUE_HIGH_ALT = 8'h18;
  localparam logic [7:0] OFS_NEXT_VALUE_LOW_ALT = 8'h1C;
  localparam logic [7:0] OFS_TRIGGER_SELECT = 8'h20;
  localparam logic [7:0] OFS_OUTPUT_MODE = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int MODE_INV_LSB = 4;
  localparam int MODE_NOV_LSB = 0;
  localparam int STAT_FRESH_BIT = 16;
  localparam int STAT_STOP_BIT = 17;
  localparam logic [15:0] RST_ENABLE = 16'h0000;
  localparam logic [15:0] RST_OUT_VALUE = 16'h0000;
  localparam logic [15:0] RST_NEXT_VALUE = 16'h0000;
  localparam logic [7:0] RST_TRIGGER_SELECT = 8'hE4;
  localparam logic [7:0] RST_OUTPUT_MODE = 8'h00;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam int BUF_DEPTH = 2;
endpackage

// >>> hdl/ppu_buf.sv
// Two-entry valid/ready buffer for next-data words.
// Assumes both sides share core_clk; handshake completes when valid and ready.
`timescale 1ns/100ps
module ppu_buf #(
  parameter int WIDTH = 16,
  parameter int DEPTH = ppu_pkg::BUF_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Refuse depths the pointer wrap cannot serve
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : gen_depth_bad
    $error("ppu_buf depth must be a power of two, at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
    logic rdy;
  } ppu_buf_t;

  ppu_buf_t r_reg;
  ppu_buf_t r_next;
  logic push;
  logic pop;

  // Handshakes on both sides
  assign push = in_valid && r_reg.rdy;
  assign pop = out_ready && (r_reg.cnt != '0);
  assign in_ready = r_reg.rdy;
  assign out_valid = (r_reg.cnt != '0);
  assign out_data = r_reg.mem[r_reg.rp];

  // Pointer and count update
  always_comb
  begin
    r_next = r_reg;
    if (push)
    begin
      r_next.mem[r_reg.wp] = in_data;
      r_next.wp = r_reg.wp + 1'b1;
    end
    if (pop)
      r_next.rp = r_reg.rp + 1'b1;
    r_next.cnt = r_reg.cnt + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    r_next.rdy = (r_next.cnt != (PW+1)'(DEPTH));
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      r_reg <= '0;
      r_reg.rdy <= 1'b1;
    end
    else
      r_reg <= r_next;
  end
endmodule

// >>> hdl/ppu_top.sv
// Pulse pattern unit: sixteen pulse outputs in four nibble groups.
// Assumes timer_time_base events on trig_in are one-cycle pulses on core_clk.
// Contract
// - sixteen outputs, four independent 4-bit groups
// - group g drives outputs 4g+3 to 4g
// - each group selects its own timer trigger
// - enabled bit copies next data on trigger
// - disabled bit never copied on trigger
// - per-bit enables, all zero after reset
// - inverted polarity and non-overlap modes offered
// - controller transfers can refill next data
// - external module stop halts operation
// - writes to enabled output bits ignored
// - transfer only on group's selected trigger; in non-overlap mode ones transfer on its companion event
// - split nibble addresses, unused nibble reads ones
//
// Design decisions made here: the AHB-Lite register port and the register offsets.
`timescale 1ns/100ps
module ppu_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [3:0] trig_in,
  input wire logic module_stop,
  input wire logic nd_valid,
  input wire logic [15:0] nd_data,
  output logic nd_ready,
  output logic [15:0] pulse_out
);
  // ****************************************
  // Decoders
  // ****************************************
  // One of four timer events by a 2-bit select
  function automatic logic ppu_pick(input logic [3:0] t, input logic [1:0] s);
    return t[s];
  endfunction

  // Per-bit mask from a 4-bit group field
  function automatic logic [15:0] ppu_spread(input logic [3:0] g);
    return {{4{g[3]}}, {4{g[2]}}, {4{g[1]}}, {4{g[0]}}};
  endfunction

  typedef struct packed {
    logic [15:0] en;
    logic [15:0] outv;
    logic [15:0] nxt;
    logic [7:0] tsel;
    logic [7:0] mode;
    logic fresh;
    logic [15:0] pins;
    logic [31:0] rdata;
    logic ready;
    logic wr_pend;
    logic rd_pend;
    logic [7:0] addr;
  } ppu_state_t;

  ppu_state_t r_reg;
  ppu_state_t r_next;
  logic [3:0] fire;
  logic [3:0] comp;
  logic buf_v;
  logic [15:0] buf_d;
  logic buf_pop;
  logic acc;
  logic wr_do;
  logic same_hi;
  logic same_lo;
  logic [3:0] nov;

  // ****************************************
  // Trigger selection
  // ****************************************
  // Main and companion event per group
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : gen_grp
      assign fire[g] = ppu_pick(trig_in, r_reg.tsel[2*g +: 2]);
      assign comp[g] = ppu_pick(trig_in, r_reg.tsel[2*g +: 2] ^ 2'h1);
    end
  endgenerate

  assign nov = r_reg.mode[ppu_pkg::MODE_NOV_LSB +: 4];
  assign same_hi = (r_reg.tsel[7:6] == r_reg.tsel[5:4]);
  assign same_lo = (r_reg.tsel[3:2] == r_reg.tsel[1:0]);
  assign acc = hsel && hready && (htrans == ppu_pkg::HTRANS_NONSEQ);
  assign wr_do = r_reg.wr_pend && !module_stop;
  assign buf_pop = buf_v && !r_reg.fresh && !module_stop;

  // Next-data refill buffer
  ppu_buf #(
    .WIDTH(16),
    .DEPTH(ppu_pkg::BUF_DEPTH)
  ) u_buf (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(nd_valid),
    .in_data(nd_data),
    .in_ready(nd_ready),
    .out_valid(buf_v),
    .out_data(buf_d),
    .out_ready(buf_pop)
  );

  // ****************************************
  // Next state
  // ****************************************
  // Bus, refill, transfer and pin update
  always_comb
  begin
    r_next = r_reg;
    r_next.ready = 1'b1;
    r_next.wr_pend = 1'b0;
    r_next.rd_pend = 1'b0;
    if (acc)
    begin
      r_next.addr = {haddr[7:2], 2'h0};
      r_next.wr_pend = hwrite;
      r_next.rd_pend = !hwrite;
      r_next.ready = hwrite;
    end
    if (buf_pop)
    begin
      r_next.nxt = buf_d;
      r_next.fresh = 1'b1;
    end
    if (wr_do)
    begin
      unique case (r_reg.addr)
        ppu_pkg::OFS_NEXT_ENABLE_HIGH: r_next.en[15:8] = hwdata[7:0];
        ppu_pkg::OFS_NEXT_ENABLE_LOW: r_next.en[7:0] = hwdata[7:0];
        ppu_pkg::OFS_OUT_VALUE_HIGH:
          r_next.outv[15:8] = (hwdata[7:0] & ~r_reg.en[15:8]) |
            (r_reg.outv[15:8] & r_reg.en[15:8]);
        ppu_pkg::OFS_OUT_VALUE_LOW:
          r_next.outv[7:0] = (hwdata[7:0] & ~r_reg.en[7:0]) |
            (r_reg.outv[7:0] & r_reg.en[7:0]);
        ppu_pkg::OFS_NEXT_VALUE_HIGH:
          if (same_hi)
            r_next.nxt[15:8] = hwdata[7:0];
          else
            r_next.nxt[15:12] = hwdata[7:4];
        ppu_pkg::OFS_NEXT_VALUE_LOW:
          if (same_lo)
            r_next.nxt[7:0] = hwdata[7:0];
          else
            r_next.nxt[7:4] = hwdata[7:4];
        ppu_pkg::OFS_NEXT_VALUE_HIGH_ALT:
          if (!same_hi)
            r_next.nxt[11:8] = hwdata[3:0];
        ppu_pkg::OFS_NEXT_VALUE_LOW_ALT:
          if (!same_lo)
            r_next.nxt[3:0] = hwdata[3:0];
        ppu_pkg::OFS_TRIGGER_SELECT: r_next.tsel = hwdata[7:0];
        ppu_pkg::OFS_OUTPUT_MODE: r_next.mode = hwdata[7:0];
        default: r_next.tsel = r_reg.tsel;
      endcase
    end
    if (!module_stop)
    begin
      // Enabled bits take next data on their group's event
      for (int b = 0; b < 16; b++)
      begin
        if (r_reg.en[b])
        begin
          if (!nov[b/4] && fire[b/4])
            r_next.outv[b] = r_reg.nxt[b];
          if (nov[b/4] && fire[b/4] && !r_reg.nxt[b])
            r_next.outv[b] = 1'b0;
          if (nov[b/4] && comp[b/4] && r_reg.nxt[b])
            r_next.outv[b] = 1'b1;
        end
      end
      if (|fire && !buf_pop)
        r_next.fresh = 1'b0;
    end
    r_next.pins = r_next.outv ^
      ppu_spread(r_next.mode[ppu_pkg::MODE_INV_LSB +: 4]);
    if (r_reg.rd_pend)
    begin
      unique case (r_reg.addr)
        ppu_pkg::OFS_NEXT_ENABLE_HIGH: r_next.rdata = {24'h0, r_reg.en[15:8]};
        ppu_pkg::OFS_NEXT_ENABLE_LOW: r_next.rdata = {24'h0, r_reg.en[7:0]};
        ppu_pkg::OFS_OUT_VALUE_HIGH: r_next.rdata = {24'h0, r_reg.outv[15:8]};
        ppu_pkg::OFS_OUT_VALUE_LOW: r_next.rdata = {24'h0, r_reg.outv[7:0]};
        ppu_pkg::OFS_NEXT_VALUE_HIGH:
          r_next.rdata = {24'h0, r_reg.nxt[15:12],
            same_hi ? r_reg.nxt[11:8] : 4'hF};
        ppu_pkg::OFS_NEXT_VALUE_LOW:
          r_next.rdata = {24'h0, r_reg.nxt[7:4], same_lo ? r_reg.nxt[3:0] : 4'hF};
        ppu_pkg::OFS_NEXT_VALUE_HIGH_ALT:
          r_next.rdata = {24'h0, 4'hF, same_hi ? 4'hF : r_reg.nxt[11:8]};
        ppu_pkg::OFS_NEXT_VALUE_LOW_ALT:
          r_next.rdata = {24'h0, 4'hF, same_lo ? 4'hF : r_reg.nxt[3:0]};
        ppu_pkg::OFS_TRIGGER_SELECT: r_next.rdata = {24'h0, r_reg.tsel};
        ppu_pkg::OFS_OUTPUT_MODE: r_next.rdata = {24'h0, r_reg.mode};
        ppu_pkg::OFS_STATUS:
          r_next.rdata = {14'h0, module_stop, r_reg.fresh, r_reg.pins};
        default: r_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      r_reg <= '0;
      r_reg.en <= ppu_pkg::RST_ENABLE;
      r_reg.outv <= ppu_pkg::RST_OUT_VALUE;
      r_reg.nxt <= ppu_pkg::RST_NEXT_VALUE;
      r_reg.tsel <= ppu_pkg::RST_TRIGGER_SELECT;
      r_reg.mode <= ppu_pkg::RST_OUTPUT_MODE;
      r_reg.ready <= 1'b1;
    end
    else
      r_reg <= r_next;
  end

  // Outputs straight from the state register, hresp tied low
  assign hreadyout = r_reg.ready;
  assign hresp = 1'b0;
  assign hrdata = r_reg.rdata;
  assign pulse_out = r_reg.pins;

  // ****************************************
  // Checks
  // ****************************************
  logic wr_ovl;
  assign wr_ovl = wr_do && (r_reg.addr == ppu_pkg::OFS_OUT_VALUE_LOW);

  sequence rd_alt_hi_s;
    acc && !hwrite && (haddr[7:0] == ppu_pkg::OFS_NEXT_VALUE_HIGH_ALT) && same_hi;
  endsequence

  sequence rd_answer_s;
    !hreadyout ##1 hreadyout;
  endsequence

  // Enabled bit copies next data
  copy_enabled_a: assert property (@(posedge core_clk) disable iff (rst)
    fire[0] && r_reg.en[0] && !nov[0] && !module_stop |=>
      r_reg.outv[0] == $past(r_reg.nxt[0]))
    else $error("enabled bit missed its transfer");

  // Disabled bit keeps its value
  disabled_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    !r_reg.en[0] && !wr_ovl |=> $stable(r_reg.outv[0]))
    else $error("disabled bit changed on trigger");

  // Enables clear under reset
  enable_reset_a: assert property (@(posedge core_clk)
    rst |=> r_reg.en == 16'h0000)
    else $error("enable bits not cleared by reset");

  // Pins follow data with inversion
  pin_follow_a: assert property (@(posedge core_clk) disable iff (rst)
    pulse_out == (r_reg.outv ^ ppu_spread(r_reg.mode[ppu_pkg::MODE_INV_LSB +: 4])))
    else $error("pin level differs from output data");

  // Locked bits refuse writes
  locked_write_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_ovl && r_reg.en[0] && !fire[0] && !comp[0] |=> $stable(r_reg.outv[0]))
    else $error("write reached an enabled output bit");

  // Module stop freezes outputs
  stop_freeze_a: assert property (@(posedge core_clk) disable iff (rst)
    module_stop |=> $stable(r_reg.outv) && $stable(r_reg.nxt))
    else $error("state changed during module stop");

  // Group 3 ignores events that are not its own
  group_alone_a: assert property (@(posedge core_clk) disable iff (rst)
    !fire[3] && !comp[3] && !wr_do |=> $stable(r_reg.outv[15:12]))
    else $error("group changed without its trigger");

  // Alternate nibble address reads ones
  alt_ones_a: assert property (@(posedge core_clk) disable iff (rst)
    rd_alt_hi_s |=> rd_answer_s ##0 (hrdata[7:0] == 8'hFF))
    else $error("unused nibble did not read as ones");

  // Refill lands in next data
  refill_load_a: assert property (@(posedge core_clk) disable iff (rst)
    buf_pop && !wr_do |=> r_reg.nxt == $past(buf_d))
    else $error("refill word not loaded");
endmodule

// >>> verification/ppu_load.sv
// External loads on the sixteen pulse pins.
// Assumes the loads sample the pins once per core_clk cycle.
`timescale 1ns/100ps
module ppu_load (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [15:0] pulse_out,
  output logic [15:0] seen_pins
);
  // Pin levels as the loads see them
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      seen_pins <= 16'h0000;
    else
      seen_pins <= pulse_out;
  end
endmodule

// >>> verification/pulse_pattern_output_bench.sv
// Self-checking bench for the pulse pattern unit.
// Assumes one AHB-Lite master, one timer event per group, one stream source.
`timescale 1ns/100ps
`define CHK(got, want) begin total_checks++; if ((got) !== (want)) begin bad_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, want); end end
module pulse_pattern_output_bench;
  logic core_clk, rst, hsel, hwrite, hready, hreadyout, hresp, module_stop, nd_valid, nd_ready;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] trig_in, inv;
  logic [15:0] nd_data, pulse_out, seen_pins, en, nxt, exp_out, d16;
  logic [15:0] w [3];
  int bad_count, total_checks, cycles, seed;
  // ****************************************
  // Clock, design and loads
  // ****************************************
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  assign hready = hreadyout;
  ppu_top u_ppu_top (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .trig_in(trig_in),
    .module_stop(module_stop), .nd_valid(nd_valid), .nd_data(nd_data),
    .nd_ready(nd_ready), .pulse_out(pulse_out));
  ppu_load u_ppu_load (.core_clk(core_clk), .rst(rst), .pulse_out(pulse_out),
    .seen_pins(seen_pins));
  // ****************************************
  // Tasks and expectations
  // ****************************************
  // One single transfer, read data left in rd
  task automatic ahb(input logic w1, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= ppu_pkg::HTRANS_NONSEQ;
    haddr <= {24'h000000, a};
    hwrite <= w1;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] want);
    ahb(1'b0, a, 8'h00);
    `CHK(rd, {24'h000000, want})
  endtask
  // One-cycle timer event, then let the transfer land
  task automatic trig(input logic [3:0] t);
    @(posedge core_clk);
    trig_in <= t;
    @(posedge core_clk);
    trig_in <= 4'h0;
    @(posedge core_clk);
  endtask
  function automatic logic [15:0] pin_f(input logic [15:0] o);
    for (int g = 0; g < 4; g++)
      o[4*g+:4] = o[4*g+:4] ^ {4{inv[g]}};
    return o;
  endfunction
  function automatic logic [15:0] upd(input logic [15:0] o, input logic [15:0] m);
    return (o & ~(en & m)) | (nxt & en & m);
  endfunction
  // Loads register the pins, so they see them one cycle later
  task automatic pins_chk;
    @(posedge core_clk);
    `CHK(pulse_out, pin_f(exp_out))
    @(posedge core_clk);
    `CHK(seen_pins, pin_f(exp_out))
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Cuts a hang short
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      finish_test();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    seed = 55210;
    {rst, hsel, hwrite, module_stop, nd_valid} = 5'b10000;
    {haddr, hwdata, htrans, trig_in, inv, nd_data} = '0;
    hsize = 3'h2;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    rchk(ppu_pkg::OFS_NEXT_ENABLE_HIGH, 8'h00);
    rchk(ppu_pkg::OFS_NEXT_ENABLE_LOW, 8'h00);
    rchk(ppu_pkg::OFS_TRIGGER_SELECT, ppu_pkg::RST_TRIGGER_SELECT);
    rchk(8'h3C, 8'h00);
    $display("reset test done");
    // Initial level while disabled
    d16 = 16'($random(seed));
    ahb(1'b1, ppu_pkg::OFS_OUT_VALUE_HIGH, d16[15:8]);
    ahb(1'b1, ppu_pkg::OFS_OUT_VALUE_LOW, d16[7:0]);
    exp_out = d16;
    pins_chk();
    // Split next data, each group on its own event
    en = 16'($random(seed));
    nxt = 16'($random(seed));
    ahb(1'b1, ppu_pkg::OFS_NEXT_ENABLE_HIGH, en[15:8]);
    ahb(1'b1, ppu_pkg::OFS_NEXT_ENABLE_LOW, en[7:0]);
    ahb(1'b1, ppu_pkg::OFS_NEXT_VALUE_HIGH, {nxt[15:12], 4'h0});
    ahb(1'b1, ppu_pkg::OFS_NEXT_VALUE_HIGH_ALT, {4'h0, nxt[11:8]});
    ahb(1'b1, ppu_pkg::OFS_NEXT_VALUE_LOW, {nxt[7:4], 4'h0});
    ahb(1'b1, ppu_pkg::OFS_NEXT_VALUE_LOW_ALT, {4'h0, nxt[3:0]});
    rchk(ppu_pkg::OFS_NEXT_VALUE_HIGH, {nxt[15:12], 4'hF});
    rchk(ppu_pkg::OFS_NEXT_VALUE_LOW_ALT, {4'hF, nxt[3:0]});
    for (int g = 0; g < 4; g++)
    begin
      trig(4'h1 << g);
      exp_out = upd(exp_out, 16'h000F << (4 * g));
      pins_chk();
    end
    rchk(ppu_pkg::OFS_OUT_VALUE_HIGH, exp_out[15:8]);
    $display("group trigger test done");
    // Writes reach disabled bits only
    d16 = 16'($random(seed));
    ahb(1'b1, ppu_pkg::OFS_OUT_VALUE_HIGH, d16[15:8]);
    ahb(1'b1, ppu_pkg::OFS_OUT_VALUE_LOW, d16[7:0]);
    exp_out = (exp_out & en) | (d16 & ~en);
    pins_chk();
    inv = 4'($random(seed));
    ahb(1'b1, ppu_pkg::OFS_OUTPUT_MODE, {inv, 4'h0});
    pins_chk();
    $display("write and invert test done");
    // Module stop freezes triggers and writes
    module_stop <= 1'b1;
    trig(4'hF);
    pins_chk();
    ahb(1'b1, ppu_pkg::OFS_NEXT_ENABLE_LOW, ~en[7:0]);
    rchk(ppu_pkg::OFS_NEXT_ENABLE_LOW, en[7:0]);
    module_stop <= 1'b0;
    $display("module stop test done");
    // Stream refill through the buffer, all groups on event 0
    ahb(1'b1, ppu_pkg::OFS_TRIGGER_SELECT, 8'h00);
    rchk(ppu_pkg::OFS_NEXT_VALUE_HIGH_ALT, 8'hFF);
    ahb(1'b1, ppu_pkg::OFS_NEXT_ENABLE_HIGH, 8'hFF);
    ahb(1'b1, ppu_pkg::OFS_NEXT_ENABLE_LOW, 8'hFF);
    en = 16'hFFFF;
    trig(4'h1);
    exp_out = nxt;
    pins_chk();
    for (int i = 0; i < 3; i++)
      w[i] = 16'($random(seed));
    @(posedge core_clk);
    nd_valid <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      nd_data <= w[i];
      do @(posedge core_clk); while (nd_ready !== 1'b1);
    end
    nd_valid <= 1'b0;
    repeat (3) @(posedge core_clk);
    `CHK(nd_ready, 1'b0)
    rchk(ppu_pkg::OFS_NEXT_VALUE_HIGH, w[0][15:8]);
    trig(4'h1);
    exp_out = w[0];
    pins_chk();
    repeat (3) @(posedge core_clk);
    rchk(ppu_pkg::OFS_NEXT_VALUE_LOW, w[1][7:0]);
    `CHK(nd_ready, 1'b1)
    $display("stream refill test done");
    // Non-overlap: zeros on the selected event, ones on its companion
    ahb(1'b1, ppu_pkg::OFS_OUTPUT_MODE, {inv, 4'hF});
    trig(4'h1);
    exp_out = exp_out & w[1];
    pins_chk();
    trig(4'h2);
    exp_out = exp_out | w[2];
    pins_chk();
    $display("non-overlap test done");
    finish_test();
  end
endmodule
